// ---- sac_pkg.sv ----
// Shared constants and types for the converter control and result block
package sac_pkg;

  // Register addresses on the special function register bus
  localparam logic [7:0] SAC_ADDR_MX = 8'hbb;    // input_channel_select
  localparam logic [7:0] SAC_ADDR_CF = 8'hbc;    // converter_config
  localparam logic [7:0] SAC_ADDR_RL = 8'hbd;    // result_low_byte
  localparam logic [7:0] SAC_ADDR_RH = 8'hbe;    // result_high_byte
  localparam logic [7:0] SAC_ADDR_CN = 8'he8;    // converter_control

  // Indirect gain register addresses, written through result_high_byte
  localparam logic [7:0] SAC_GAIN_HI = 8'h04;    // gain_high_byte
  localparam logic [7:0] SAC_GAIN_LO = 8'h07;    // gain_low_nibble
  localparam logic [7:0] SAC_GAIN_EX = 8'h08;    // gain_extra_step

  // Reset values
  localparam logic [7:0] SAC_MX_RESET = 8'h1f;
  localparam logic [7:0] SAC_CF_RESET = 8'hf8;
  localparam logic [7:0] SAC_CN_RESET = 8'h00;
  localparam logic [7:0] SAC_RES_RESET = 8'h00;
  localparam logic [7:0] SAC_GHI_RESET = 8'hfc;
  localparam logic [7:0] SAC_GLO_RESET = 8'h00;
  localparam logic [7:0] SAC_GEX_RESET = 8'h01;

  // converter_control bit positions
  localparam int SAC_CN_EN    = 7;
  localparam int SAC_CN_BURST = 6;
  localparam int SAC_CN_DONE  = 5;
  localparam int SAC_CN_BUSY  = 4;
  localparam int SAC_CN_WIN   = 3;
  localparam int SAC_CN_LJST  = 2;
  localparam int SAC_CN_CM_HI = 1;
  localparam int SAC_CN_CM_LO = 0;

  // converter_config field positions
  localparam int SAC_CF_DIV_HI = 7;
  localparam int SAC_CF_DIV_LO = 3;
  localparam int SAC_CF_RPT_HI = 2;
  localparam int SAC_CF_RPT_LO = 1;
  localparam int SAC_CF_GAIN_PROGRAM_ENABLE = 0;

  // Gain field positions
  localparam int SAC_GLO_HI = 7;
  localparam int SAC_GLO_LO = 4;
  localparam int SAC_GEX_BIT = 0;

  // Input select codes
  localparam logic [4:0] SAC_SEL_TEMP   = 5'h18;
  localparam logic [4:0] SAC_SEL_SUPPLY = 5'h19;
  localparam logic [4:0] SAC_SEL_GND_LO = 5'h1a;

  // Start sources
  localparam logic [1:0] SAC_CM_SOFT   = 2'h0;
  localparam logic [1:0] SAC_CM_TIMER1 = 2'h1;
  localparam logic [1:0] SAC_CM_PIN    = 2'h2;
  localparam logic [1:0] SAC_CM_TIMER2 = 2'h3;

  // Last index of each accumulation series (1, 4, 8, 16 conversions)
  localparam logic [3:0] SAC_RPT1_LAST  = 4'h0;
  localparam logic [3:0] SAC_RPT4_LAST  = 4'h3;
  localparam logic [3:0] SAC_RPT8_LAST  = 4'h7;
  localparam logic [3:0] SAC_RPT16_LAST = 4'hf;

  // Conversion clocks per conversion, last count index
  localparam logic [3:0] SAC_SAR_LAST = 4'hc;

  // Extra gain step in units of 1/4096 (one sixty-fourth)
  localparam logic [12:0] SAC_EXTRA_UNITS = 13'h0040;

  // Sequencer states
  typedef enum logic [0:0] {SAC_IDLE, SAC_CONVERT} sac_state_t;

endpackage

// ---- sac_core_if.sv ----
// Internal carrier between controller, clock divider and accumulator
`timescale 1ns/100ps
`default_nettype none
interface sac_core_if;
  logic        run;           // Conversion in progress
  logic [4:0]  divider;       // Conversion clock divider field
  logic        burst;         // Burst oscillator feeds the divider
  logic        tick;          // One conversion clock period elapsed
  logic        sample_valid;  // Result of one conversion ready
  logic [11:0] sample;        // Raw 12-bit code
  logic        abort;         // Discard a partial series
  logic [1:0]  repeat_sel;    // Repeat field
  logic        left_just;     // Justification select
  logic        series_end;    // Last conversion of a series
  logic        wr_hi;         // Software write to result high byte
  logic        wr_lo;         // Software write to result low byte
  logic [7:0]  wdata;         // Software write data
  logic [7:0]  res_hi;        // Formatted high byte
  logic [7:0]  res_lo;        // Formatted low byte
  logic [15:0] result_word;   // Raw accumulated result

  modport ctl (output run, divider, burst, sample_valid, sample, abort, repeat_sel,
               left_just, wr_hi, wr_lo, wdata,
               input tick, series_end, res_hi, res_lo, result_word);
  modport div (input run, divider, burst, output tick);
  modport acc (input sample_valid, sample, abort, repeat_sel, left_just, wr_hi, wr_lo,
               wdata, output series_end, res_hi, res_lo, result_word);
endinterface
`default_nettype wire

// ---- sac_clk_div.sv ----
// Conversion clock divider from the functional clock, or from burst oscillator edges in burst mode
`timescale 1ns/100ps
`default_nettype none
module sac_clk_div (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic burst_osc,
  sac_core_if.div   cif
);

  // Divider state
  typedef struct packed {
    logic       osc_s1;   // Synchroniser first stage
    logic       osc_s2;   // Synchroniser second stage
    logic       osc_prev; // Previous synchronised level
    logic [4:0] cnt;      // Functional clock count
    logic       tick;     // Registered conversion clock tick
  } sac_div_t;

  localparam sac_div_t SAC_DIV_RESET = '0;

  sac_div_t st;
  sac_div_t next_st;
  logic     functional_clock_tick;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st        = st;
    next_st.osc_s1 = burst_osc;
    next_st.osc_s2 = st.osc_s1;
    next_st.osc_prev = st.osc_s2;
    next_st.tick   = 1'b0;
    functional_clock_tick = cif.burst ? (st.osc_s2 & ~st.osc_prev) : 1'b1;
    if (!cif.run) begin
      next_st.cnt = 5'h00;
    end else if (functional_clock_tick) begin
      if (st.cnt == cif.divider) begin
        next_st.cnt  = 5'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 5'h01;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= SAC_DIV_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cif.tick = st.tick;

endmodule
`default_nettype wire

// ---- sac_accum.sv ----
// Accumulator and result justification
`timescale 1ns/100ps
`default_nettype none
module sac_accum (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  sac_core_if.acc   cif
);

  // Accumulator state
  typedef struct packed {
    logic [3:0]  cnt;     // Conversions taken in this series
    logic [15:0] sum;     // Running sum
    logic [15:0] result;  // Result register
  } sac_acc_t;

  localparam sac_acc_t SAC_ACC_RESET = '0;

  sac_acc_t    st;
  sac_acc_t    next_st;
  logic [3:0]  last;
  logic [15:0] sum_in;

  //////////////////////////////////////////////////////////////////////////////
  // Series length and summing
  always_comb begin
    case (cif.repeat_sel)
      2'h0:    last = sac_pkg::SAC_RPT1_LAST;
      2'h1:    last = sac_pkg::SAC_RPT4_LAST;
      2'h2:    last = sac_pkg::SAC_RPT8_LAST;
      default: last = sac_pkg::SAC_RPT16_LAST;
    endcase
    sum_in  = ((st.cnt == 4'h0) ? 16'h0000 : st.sum) + {4'h0, cif.sample};
    next_st = st;
    if (cif.abort) begin
      next_st.cnt = 4'h0;
    end else if (cif.sample_valid) begin
      if (st.cnt == last) begin
        next_st.result = sum_in;
        next_st.cnt    = 4'h0;
      end else begin
        next_st.sum = sum_in;
        next_st.cnt = st.cnt + 4'h1;
      end
    end
    // Software result writes, also taken while the converter is shut down
    if (cif.wr_hi && !cif.sample_valid) begin
      next_st.result[15:8] = cif.wdata;
    end
    if (cif.wr_lo && !cif.sample_valid) begin
      next_st.result[7:0] = cif.wdata;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= SAC_ACC_RESET;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    cif.series_end  = cif.sample_valid & ~cif.abort & (st.cnt == last);
    cif.result_word = st.result;
    if (cif.left_just) begin
      cif.res_hi = st.result[11:4];
      cif.res_lo = {st.result[3:0], 4'h0};
    end else begin
      cif.res_hi = st.result[15:8];
      cif.res_lo = st.result[7:0];
    end
  end

endmodule
`default_nettype wire

// ---- sac_control.sv ----
// Converter control registers, start sequencing and gain programming
`timescale 1ns/100ps
`default_nettype none
module sac_control (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        timer1_overflow,
  input  wire logic        timer2_overflow,
  input  wire logic        external_start_pin,
  input  wire logic        burst_osc,
  input  wire logic [11:0] sar_result,
  input  wire logic        window_match,
  output logic      [4:0]  input_select_field,
  output logic             mux_port_en,
  output logic             mux_temp_en,
  output logic             mux_supply_en,
  output logic             mux_ground_en,
  output logic             converter_enable,
  output logic             conversion_clock,
  output logic             sar_sample_start,
  output logic             conversion_busy,
  output logic             conversion_done_interrupt,
  output logic             window_compare_interrupt,
  output logic      [15:0] result_word,
  output logic      [11:0] gain_word,
  output logic             extra_gain_bit,
  output logic      [12:0] gain_units
);

  //////////////////////////////////////////////////////////////////////////////
  // Controller state
  typedef struct packed {
    logic [4:0]         mx;         // Input select field
    logic [4:0]         div;        // Conversion clock divider
    logic [1:0]         rpt;        // Repeat field
    logic               gain_en;    // Gain programming enable
    logic               en;         // Converter enable
    logic               burst;      // Burst mode enable
    logic               done;       // Conversion done flag
    logic               wflag;      // Window match flag
    logic               ljst;       // Left justify select
    logic [1:0]         cm;         // Start source select
    sac_pkg::sac_state_t state;     // Sequencer state
    logic [3:0]         sar_cnt;    // Conversion clocks in this conversion
    logic [7:0]         gain_addr;  // Selected gain register
    logic [7:0]         gain_hi;    // Gain word upper byte
    logic [3:0]         gain_lo;    // Gain word lower nibble
    logic               gain_add;   // Extra gain bit
    logic               ext_s1;     // Start pin synchroniser first stage
    logic               ext_s2;     // Start pin synchroniser second stage
    logic               ext_prev;   // Previous synchronised level
    logic               start_p;    // Registered conversion start pulse
  } sac_ctl_t;

  localparam sac_ctl_t SAC_CTL_RESET = '{
    mx:        sac_pkg::SAC_MX_RESET[4:0],
    div:       sac_pkg::SAC_CF_RESET[7:3],
    rpt:       sac_pkg::SAC_CF_RESET[2:1],
    gain_en:   sac_pkg::SAC_CF_RESET[0],
    en:        sac_pkg::SAC_CN_RESET[7],
    burst:     sac_pkg::SAC_CN_RESET[6],
    done:      sac_pkg::SAC_CN_RESET[5],
    wflag:     sac_pkg::SAC_CN_RESET[3],
    ljst:      sac_pkg::SAC_CN_RESET[2],
    cm:        sac_pkg::SAC_CN_RESET[1:0],
    state:     sac_pkg::SAC_IDLE,
    sar_cnt:   4'h0,
    gain_addr: 8'h00,
    gain_hi:   sac_pkg::SAC_GHI_RESET,
    gain_lo:   sac_pkg::SAC_GLO_RESET[7:4],
    gain_add:  sac_pkg::SAC_GEX_RESET[0],
    ext_s1:    1'b0,
    ext_s2:    1'b0,
    ext_prev:  1'b0,
    start_p:   1'b0
  };

  sac_ctl_t st;       // Current state
  sac_ctl_t next_st;  // Next state

  logic wr_mx;        // Write strobes per register
  logic wr_cf;
  logic wr_cn;
  logic wr_rh;
  logic wr_rl;
  logic ext_rise;     // Synchronised start pin rising edge
  logic start_evt;    // Selected start source fired
  logic conv_end;     // Last conversion clock of a conversion

  sac_core_if cif ();

  //////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  sac_clk_div u_div (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .burst_osc (burst_osc),
    .cif       (cif.div)
  );

  sac_accum u_acc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .cif      (cif.acc)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  always_comb begin
    wr_mx = sfr_wr & (sfr_addr == sac_pkg::SAC_ADDR_MX);
    wr_cf = sfr_wr & (sfr_addr == sac_pkg::SAC_ADDR_CF);
    wr_cn = sfr_wr & (sfr_addr == sac_pkg::SAC_ADDR_CN);
    wr_rh = sfr_wr & (sfr_addr == sac_pkg::SAC_ADDR_RH);
    wr_rl = sfr_wr & (sfr_addr == sac_pkg::SAC_ADDR_RL);
  end

  // Start source selection
  always_comb begin
    ext_rise = st.ext_s2 & ~st.ext_prev;
    case (st.cm)
      // busy write one in software mode
      sac_pkg::SAC_CM_SOFT:   start_evt = wr_cn & sfr_wdata[sac_pkg::SAC_CN_BUSY];
      sac_pkg::SAC_CM_TIMER1: start_evt = timer1_overflow;
      sac_pkg::SAC_CM_PIN:    start_evt = ext_rise;
      sac_pkg::SAC_CM_TIMER2: start_evt = timer2_overflow;
      default:                start_evt = 1'b0;
    endcase
    conv_end = (st.state == sac_pkg::SAC_CONVERT) & cif.tick
             & (st.sar_cnt == sac_pkg::SAC_SAR_LAST);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st          = st;
    next_st.ext_s1   = external_start_pin;
    next_st.ext_s2   = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    next_st.start_p  = 1'b0;

    // Channel select, upper bits dropped
    if (wr_mx) begin
      next_st.mx = sfr_wdata[4:0];
    end
    // Configuration register
    if (wr_cf) begin
      next_st.div     = sfr_wdata[sac_pkg::SAC_CF_DIV_HI:sac_pkg::SAC_CF_DIV_LO];
      next_st.rpt     = sfr_wdata[sac_pkg::SAC_CF_RPT_HI:sac_pkg::SAC_CF_RPT_LO];
      next_st.gain_en = sfr_wdata[sac_pkg::SAC_CF_GAIN_PROGRAM_ENABLE];
    end
    // Control register, flags written as plain bits
    if (wr_cn) begin
      next_st.en    = sfr_wdata[sac_pkg::SAC_CN_EN];
      next_st.burst = sfr_wdata[sac_pkg::SAC_CN_BURST];
      next_st.done  = sfr_wdata[sac_pkg::SAC_CN_DONE];
      next_st.wflag = sfr_wdata[sac_pkg::SAC_CN_WIN];
      next_st.ljst  = sfr_wdata[sac_pkg::SAC_CN_LJST];
      next_st.cm    = sfr_wdata[sac_pkg::SAC_CN_CM_HI:sac_pkg::SAC_CN_CM_LO];
    end

    // Indirect gain programming
    if (st.gain_en) begin
      // high byte write selects gain address
      if (wr_rh) begin
        next_st.gain_addr = sfr_wdata;
      end
      // low byte write loads gain register
      if (wr_rl) begin
        case (st.gain_addr)
          sac_pkg::SAC_GAIN_HI: next_st.gain_hi = sfr_wdata;
          sac_pkg::SAC_GAIN_LO:
            next_st.gain_lo = sfr_wdata[sac_pkg::SAC_GLO_HI:sac_pkg::SAC_GLO_LO];
          sac_pkg::SAC_GAIN_EX: next_st.gain_add = sfr_wdata[sac_pkg::SAC_GEX_BIT];
          default: ;
        endcase
      end
    end

    // Conversion sequencer
    case (st.state)
      sac_pkg::SAC_IDLE: begin
        next_st.sar_cnt = 4'h0;
        if (st.en && start_evt) begin
          next_st.state   = sac_pkg::SAC_CONVERT;
          next_st.start_p = 1'b1;
        end
      end
      sac_pkg::SAC_CONVERT: begin
        if (!st.en) begin
          // Shutdown abandons the conversion
          next_st.state = sac_pkg::SAC_IDLE;
        end else if (conv_end) begin
          next_st.sar_cnt = 4'h0;
          if (st.burst && !cif.series_end) begin
            next_st.start_p = 1'b1;
          end else begin
            next_st.state = sac_pkg::SAC_IDLE;
          end
        end else if (cif.tick) begin
          next_st.sar_cnt = st.sar_cnt + 4'h1;
        end
      end
      default: begin
        next_st.state = sac_pkg::SAC_IDLE;
      end
    endcase

    // done flag on the busy fall that ends a series, set wins
    if (conv_end && cif.series_end) begin
      next_st.done = 1'b1;
    end
    // window flag set by hardware or by a control write, hardware set wins
    if (window_match) begin
      next_st.wflag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= SAC_CTL_RESET;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Carrier drive
  always_comb begin
    cif.run          = (st.state == sac_pkg::SAC_CONVERT);
    cif.divider      = st.div;
    cif.burst        = st.burst;
    // Result sampled on the last conversion clock
    cif.sample_valid = conv_end & st.en;
    cif.sample       = sar_result;
    cif.abort        = ~st.en;
    cif.repeat_sel   = st.rpt;
    cif.left_just    = st.ljst;
    // Result bytes writable only outside gain programming
    cif.wr_hi        = wr_rh & ~st.gain_en;
    cif.wr_lo        = wr_rl & ~st.gain_en;
    cif.wdata        = sfr_wdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read mux
  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        sac_pkg::SAC_ADDR_MX: sfr_rdata = {3'h0, st.mx};
        sac_pkg::SAC_ADDR_CF: sfr_rdata = {st.div, st.rpt, st.gain_en};
        sac_pkg::SAC_ADDR_RL: sfr_rdata = cif.res_lo;
        sac_pkg::SAC_ADDR_RH: sfr_rdata = cif.res_hi;
        sac_pkg::SAC_ADDR_CN: sfr_rdata = {st.en, st.burst, st.done, cif.run,
                                           st.wflag, st.ljst, st.cm};
        // gain registers have no read path
        default:              sfr_rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Analog side outputs
  always_comb begin
    input_select_field = st.mx;
    mux_port_en   = ~st.mx[4];
    mux_temp_en   = (st.mx == sac_pkg::SAC_SEL_TEMP);
    mux_supply_en = (st.mx == sac_pkg::SAC_SEL_SUPPLY);
    mux_ground_en = (st.mx >= sac_pkg::SAC_SEL_GND_LO);
    converter_enable          = st.en;
    conversion_clock          = cif.tick;
    sar_sample_start          = st.start_p;
    conversion_busy           = cif.run;
    conversion_done_interrupt = st.done;
    window_compare_interrupt  = st.wflag;
    result_word               = cif.result_word;
    gain_word      = {st.gain_hi, st.gain_lo};
    extra_gain_bit = st.gain_add;
    gain_units = {1'b0, gain_word} + (st.gain_add ? sac_pkg::SAC_EXTRA_UNITS : 13'h0000);
  end

endmodule
`default_nettype wire

// ---- sac_control_props.sv ----
// Port checker for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sac_control_props (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        window_match,
  input wire logic [4:0]  input_select_field,
  input wire logic        mux_temp_en,
  input wire logic        mux_ground_en,
  input wire logic        sar_sample_start,
  input wire logic        conversion_busy,
  input wire logic        conversion_done_interrupt,
  input wire logic        window_compare_interrupt,
  input wire logic [11:0] gain_word,
  input wire logic        extra_gain_bit,
  input wire logic [12:0] gain_units
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Software start written to an idle block
  sequence s_soft_start;
    sfr_wr && sfr_addr == 8'he8 && sfr_wdata[7] && sfr_wdata[4] && sfr_wdata[1:0] == 2'h0
      && !conversion_busy;
  endsequence
  // Done flag rises with no register write just before it
  sequence s_done_rise;
    !conversion_done_interrupt && !sfr_wr ##1 conversion_done_interrupt;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_SOFT_START: assert property (s_soft_start |-> ##[1:2] (sar_sample_start && conversion_busy))
    else $error("software start not taken");
  AST_BUSY_SAMPLE: assert property (sar_sample_start |-> conversion_busy)
    else $error("sample start while not busy");
  AST_DONE_FALL: assert property (s_done_rise |-> $fell(conversion_busy))
    else $error("done flag rose without busy falling");
  AST_WIN_SET: assert property (window_match |=> window_compare_interrupt)
    else $error("window flag not set");
  AST_WIN_HOLD: assert property (window_compare_interrupt && !(sfr_wr && sfr_addr == 8'he8) |=> window_compare_interrupt)
    else $error("window flag cleared by hardware");
  AST_TEMP_SEL: assert property (mux_temp_en == (input_select_field == 5'h18))
    else $error("sensor select decode");
  AST_GND_SEL: assert property (mux_ground_en == (input_select_field >= 5'h1a))
    else $error("ground select decode");
  AST_GAIN_SUM: assert property (gain_units == {1'b0, gain_word} + (extra_gain_bit ? 13'h0040 : 13'h0000))
    else $error("gain units wrong");
  AST_MX_TOP: assert property (sfr_rd && sfr_addr == 8'hbb |-> sfr_rdata[7:5] == 3'h0)
    else $error("channel select upper bits not zero");
  AST_GAIN_NO_READ: assert property (sfr_rd && sfr_addr inside {8'h04, 8'h07, 8'h08} |-> sfr_rdata == 8'h00)
    else $error("gain register readable");
endmodule
bind sac_control sac_control_props sac_control_props_i (.core_clk, .sys_rst, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata, .window_match, .input_select_field, .mux_temp_en,
  .mux_ground_en, .sar_sample_start, .conversion_busy, .conversion_done_interrupt,
  .window_compare_interrupt, .gain_word, .extra_gain_bit, .gain_units);
`default_nettype wire

// ---- sac_sar_model.sv ----
// Behavioural analog converter and window comparator
`timescale 1ns/100ps
`default_nettype none
module sac_sar_model #(parameter logic [11:0] CODE = 12'habc) (
  input  wire logic        win_fire,
  output logic      [11:0] sar_result,
  output logic             window_match
);
  // Fixed code keeps expected sums known
  assign sar_result   = CODE;
  // Comparator pulse on bench request
  assign window_match = win_fire;
endmodule
`default_nettype wire

// ---- sac_control_bench.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sac_control_bench;
  typedef struct packed {logic [7:0] cf, cn, hi, lo;} sac_row_t;
  logic        core_clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic        t1 = 1'b0, t2 = 1'b0, pin = 1'b0, burst_osc = 1'b0, win_fire = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [11:0] sar_result, gain_word;
  logic [12:0] gain_units;
  logic        window_match, mux_temp_en, conversion_done_interrupt, mux_supply_en;
  logic        mux_port_en, converter_enable, conversion_clock;
  logic [4:0]  input_select_field;
  logic [15:0] result_word;
  int          errors = 0, n_compared = 0, n_ticks = 0;
  // Result rows: config, control, high and low byte
  sac_row_t    rows [5] = '{'{8'h08, 8'h90, 8'h0a, 8'hbc}, '{8'h0a, 8'hd0, 8'h2a, 8'hf0},
    '{8'h0c, 8'hd0, 8'h55, 8'he0}, '{8'h0e, 8'hd0, 8'hab, 8'hc0}, '{8'h08, 8'h94, 8'hab, 8'hc0}};
  logic [7:0]  gw [6] = '{8'h04, 8'h6c, 8'h07, 8'ha0, 8'h08, 8'h00};
  logic [15:0] rv [5] = '{16'hbb1f, 16'hbcf8, 16'he800, 16'hbd00, 16'hbe00};
  always #10 core_clk = ~core_clk;
  always #30 burst_osc = ~burst_osc;
  // Conversion clock pulses seen, counted away from the launching edge
  always @(negedge core_clk)
    if (conversion_clock === 1'b1) n_ticks++;
  sac_sar_model sac_sar_model_i (.win_fire, .sar_result, .window_match);
  sac_control sac_control_i (.core_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .timer1_overflow(t1), .timer2_overflow(t2), .external_start_pin(pin),
    .burst_osc, .sar_result, .window_match, .input_select_field, .mux_port_en,
    .mux_temp_en, .mux_supply_en, .mux_ground_en(), .converter_enable,
    .conversion_clock, .sar_sample_start(), .conversion_busy(), .conversion_done_interrupt,
    .window_compare_interrupt(), .result_word, .gain_word, .extra_gain_bit(), .gain_units);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    {sfr_rd, sfr_addr} = {1'b1, a};
    #5 chk({8'h00, sfr_rdata}, {8'h00, e});
    @(negedge core_clk);
    sfr_rd = 1'b0;
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 4000 && conversion_done_interrupt !== 1'b1; i++) @(posedge core_clk);
    if (i == 4000) begin
      errors++;
      $display("wrong value %0t conversion never finished", $time);
      test_done;
    end
  endtask
  // Timer pulse or pin edge for one start source
  task automatic fire(input int cm);
    @(negedge core_clk);
    t1 = (cm == 1);
    t2 = (cm == 3);
    pin = (cm == 2);
    @(negedge core_clk);
    {t1, t2} = 2'b00;
    repeat (3) @(negedge core_clk);
    pin = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) sys_rst = 1'b0;
    foreach (rows[k]) begin
      wr(8'hbc, rows[k].cf);
      wr(8'he8, 8'h80);
      wr(8'he8, rows[k].cn);
      wait_done;
      rd(8'hbe, rows[k].hi);
      rd(8'hbd, rows[k].lo);
      rd(8'he8, (rows[k].cn & 8'hef) | 8'h20);
    end
    chk(16'(n_ticks), 16'(30 * (sac_pkg::SAC_SAR_LAST + 4'h1)));
    for (int cm = 1; cm < 4; cm++) begin
      wr(8'he8, 8'h80 | 8'(cm));
      wr(8'he8, 8'h90 | 8'(cm));
      repeat (40) @(negedge core_clk);
      rd(8'he8, 8'h80 | 8'(cm));
      fire(cm);
      wait_done;
      rd(8'hbd, 8'hbc);
    end
    chk(result_word, 16'h0abc);
    chk({15'h0, converter_enable}, 16'h0001);
    wr(8'hbc, 8'h09);
    foreach (gw[k]) wr(k % 2 ? 8'hbd : 8'hbe, gw[k]);
    chk({4'h0, gain_word}, 16'h06ca);
    wr(8'hbe, 8'h08);
    wr(8'hbd, 8'h01);
    chk({3'h0, gain_units}, 16'h070a);
    rd(8'h04, 8'h00);
    rd(8'hbe, 8'h0a);
    rd(8'hbd, 8'hbc);
    wr(8'hbc, 8'h08);
    wr(8'hbb, 8'hf8);
    rd(8'hbb, 8'h18);
    chk({15'h0, mux_temp_en}, 16'h0001);
    wr(8'hbb, 8'h19);
    chk({9'h0, input_select_field, mux_supply_en, mux_port_en}, 16'h0066);
    wr(8'hbb, 8'h05);
    chk({9'h0, input_select_field, mux_supply_en, mux_port_en}, 16'h0015);
    @(negedge core_clk) win_fire = 1'b1;
    @(negedge core_clk) win_fire = 1'b0;
    rd(8'he8, 8'hab);
    wr(8'he8, 8'h80);
    rd(8'he8, 8'h80);
    rd(8'h00, 8'h00);
    @(negedge core_clk) sys_rst = 1'b1;
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    foreach (rv[k]) rd(rv[k][15:8], rv[k][7:0]);
    chk({3'h0, gain_units}, 16'h1000);
    chk({15'h0, converter_enable}, 16'h0000);
    wr(8'hbd, 8'h5a);
    rd(8'hbd, 8'h5a);
    test_done;
  end
endmodule
`default_nettype wire
